// >>> mrw_params.svh
`ifndef MRW_PARAMS_SVH
`define MRW_PARAMS_SVH
// ****************************************
// Register offsets on the control bus
// ****************************************
`define MRW_OFS_MAP_CTL 5'h00
`define MRW_OFS_WIN_BASE 5'h04
`define MRW_OFS_ENDIAN 5'h08
`define MRW_OFS_SWAP 5'h0c
`define MRW_OFS_SEQ_OPT 5'h10
`define MRW_OFS_MISC 5'h14
`define MRW_OFS_ADV_FUNC 5'h18
`define MRW_OFS_STATUS 5'h1c
// ****************************************
// Field positions and encodings
// ****************************************
`define MRW_MAP_SEL_LEGACY 2'h2
`define MRW_MAP_SEL_NEW 2'h3
`define MRW_MAP_SEL_OFF 2'h0
`define MRW_SEQ_MMIO_ONLY_BIT 7
`define MRW_MISC_WIDE_WR_BIT 9
`define MRW_ADV_LEGACY_BIT 5
// ****************************************
// Legacy A segment layout
// ****************************************
`define MRW_LEG_SEG 16'h000a
`define MRW_LEG_REG_FLOOR 16'h8000
// ****************************************
// New window layout, offsets in one half
// ****************************************
`define MRW_LIN_SIZE 25'h0400000
`define MRW_IMG_LO 25'h1000000
`define MRW_IMG_HI 25'h1007fff
`define MRW_PCI_LO 25'h1008000
`define MRW_PCI_HI 25'h100803f
`define MRW_PACK_LO 25'h1008100
`define MRW_PACK_HI 25'h100816f
`define MRW_CURY 25'h10082e8
`define MRW_CURY2 25'h10082ea
`define MRW_VGA_LO 25'h10083b0
`define MRW_VGA_HI 25'h10083df
`define MRW_SETUP_SEL 25'h1008502
`define MRW_SUBSYS_STAT 25'h1008504
`define MRW_VIDEO_EN 25'h1008508
`define MRW_ADV_FUNC 25'h100850c
`define MRW_ENH_LO 25'h10086e8
`define MRW_ENH_HI 25'h100eeea
`define MRW_PFD_LO 25'h1010000
`define MRW_PFD_HI 25'h1013fff
`define MRW_PFM_LO 25'h1014000
`define MRW_PFM_HI 25'h1017fff
`define MRW_PFR_LO 25'h1018080
`define MRW_PFR_HI 25'h101809f
`endif

// >>> mrw_pkg.sv
package mrw_pkg;
  // Target of a decoded host memory cycle
  typedef enum logic [3:0] {
    MRW_RG_NONE = 4'h0,
    MRW_RG_LINEAR = 4'h1,
    MRW_RG_IMAGE = 4'h2,
    MRW_RG_PCI_CFG = 4'h3,
    MRW_RG_PACKED = 4'h4,
    MRW_RG_ENH_REG = 4'h5,
    MRW_RG_VGA = 4'h6,
    MRW_RG_SYS_REG = 4'h7,
    MRW_RG_PF_DATA = 4'h8,
    MRW_RG_PF_MASK = 4'h9,
    MRW_RG_PF_REG = 4'ha
  } mrw_region_t;
  // Control bus slave states
  typedef enum logic [1:0] {
    MRW_WB_IDLE = 2'b01,
    MRW_WB_ANSWER = 2'b10
  } mrw_wb_state_t;
endpackage

// >>> mrw_region_decode.sv
`timescale 1ns/1ps
`include "mrw_params.svh"
module mrw_region_decode (
  // Offset inside one endian half
  input wire logic [24:0] half_offset,
  input wire logic packed_en,
  // Decoded target
  output mrw_pkg::mrw_region_t region
);
  import mrw_pkg::*;

  // ****************************************
  // Range tests
  // ****************************************
  function automatic logic in_range(input logic [24:0] a, input logic [24:0] lo, input logic [24:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  // lowest 4 MB backed
  // Only the lowest part of the linear area has memory behind it
  wire is_linear = (half_offset < `MRW_LIN_SIZE);
  wire is_image = in_range(half_offset, `MRW_IMG_LO, `MRW_IMG_HI);
  wire is_pci = in_range(half_offset, `MRW_PCI_LO, `MRW_PCI_HI);
  wire is_packed = packed_en && in_range(half_offset, `MRW_PACK_LO, `MRW_PACK_HI);
  wire is_cury = (half_offset == `MRW_CURY) || (half_offset == `MRW_CURY2);
  wire is_vga = in_range(half_offset, `MRW_VGA_LO, `MRW_VGA_HI);
  wire is_sys = (half_offset == `MRW_SETUP_SEL) || (half_offset == `MRW_SUBSYS_STAT) ||
                (half_offset == `MRW_VIDEO_EN) || (half_offset == `MRW_ADV_FUNC);
  wire is_enh = in_range(half_offset, `MRW_ENH_LO, `MRW_ENH_HI);
  wire is_pfd = in_range(half_offset, `MRW_PFD_LO, `MRW_PFD_HI);
  wire is_pfm = in_range(half_offset, `MRW_PFM_LO, `MRW_PFM_HI);
  wire is_pfr = in_range(half_offset, `MRW_PFR_LO, `MRW_PFR_HI);

  // ****************************************
  // Region select, ranges never overlap
  // ****************************************
  assign region = is_linear ? MRW_RG_LINEAR :
                  is_image ? MRW_RG_IMAGE :
                  is_pci ? MRW_RG_PCI_CFG :
                  is_packed ? MRW_RG_PACKED :
                  (is_cury || is_enh) ? MRW_RG_ENH_REG :
                  is_vga ? MRW_RG_VGA :
                  is_sys ? MRW_RG_SYS_REG :
                  is_pfd ? MRW_RG_PF_DATA :
                  is_pfm ? MRW_RG_PF_MASK :
                  is_pfr ? MRW_RG_PF_REG : MRW_RG_NONE;
endmodule

// >>> mrw_window_decoder.sv
`timescale 1ns/1ps
`include "mrw_params.svh"
// Contract
// - Select field value 10b turns on the legacy fixed A-segment mapping.
// - With select bit 3 clear, advanced-function bit 5 also turns on legacy.
// - Legacy accesses A0000-A7FFF go to the pixel data transfer port.
// - Legacy register accesses decode in A8000-AFFFF at their I/O address.
// - Legacy takes 16-bit accesses; 32-bit writes only with misc bit 9 set.
// - New mapping decodes 64 MB at base; low half little, high half big endian.
// - Select value 11b turns on new mapping; PCI strap resets to it.
// - VL-Bus strap resets the select field to 00b, both schemes off.
// - With mapping on, sequencer bit 7 picks I/O plus memory or memory only.
// - Offsets 100 0000 to 100 7FFF reach the image transfer port.
// - System registers sit at 100 8502, 8504, 8508 and 850C.
// - Pixel formatter data from 101 0000, mask data from 101 4000.
// - Position registers at 100 82E8/82EA; enhanced registers up to 100 EEEA.
// - Big endian half repeats the little endian layout 32 MB higher.
// - Window address is base bits 7-2 on address 31-26 plus the offset.
// - New mapping takes 16-bit reads and writes, 32-bit only as writes.
// - Big endian swap comes from map, swap or endian control per area.
// - A 32-bit packed write updates a register pair; packed reads are 16-bit.
// - Packed pairs 8100-816C decode whenever the new mapping (select 11b, map bit 3 set) is on.
// - Only the lowest 4 MB of each linear area is backed by memory.
module mrw_window_decoder (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // Bus configuration strap, high for PCI
  input wire logic PCI_STRAP,
  // Classic Wishbone control slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [4:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  output logic WB_ERR_O,
  // Host memory cycle request
  input wire logic HOST_REQ,
  input wire logic [31:0] HOST_ADDR,
  input wire logic HOST_WE,
  input wire logic [3:0] HOST_BE,
  // Decode result
  output logic DEC_VALID,
  output logic DEC_CLAIM,
  output logic DEC_REJECT,
  output mrw_pkg::mrw_region_t DEC_REGION,
  output logic [21:0] DEC_OFFSET,
  output logic DEC_BIG,
  output logic [1:0] DEC_SWAP,
  output logic DEC_PAIR,
  // Port I/O register access allowed
  output logic IO_PORT_EN
);
  import mrw_pkg::*;

  // ****************************************
  // Helper functions
  // ****************************************
  // Byte enables of a 16-bit access in either half of the word
  function automatic logic is_half(input logic [3:0] be);
    is_half = (be == 4'h3) || (be == 4'hc);
  endfunction

  // Register-like targets obey the width limits
  function automatic logic is_reg_area(input mrw_region_t r);
    is_reg_area = (r == MRW_RG_PACKED) || (r == MRW_RG_ENH_REG) || (r == MRW_RG_SYS_REG) ||
                  (r == MRW_RG_PF_REG);
  endfunction

  // ****************************************
  // Strap synchroniser
  // ****************************************
  logic strap_meta_reg;
  logic strap_sync_reg;

  // Strap is a pin, two stages before use
  always_ff @(posedge CLK_SYS) begin
    strap_meta_reg <= PCI_STRAP;
    strap_sync_reg <= strap_meta_reg;
  end

  // ****************************************
  // Control registers
  // ****************************************
  logic [1:0] map_sel_reg;
  logic [1:0] lin_swap_reg;
  logic [5:0] win_base_reg;
  logic [1:0] endian_reg;
  logic [1:0] img_swap_reg;
  logic mmio_only_reg;
  logic wide_wr_reg;
  logic adv_legacy_reg;
  mrw_wb_state_t wb_state_reg;
  mrw_wb_state_t wb_state_next;
  logic [31:0] rd_data_reg;
  logic miss_reg;

  // Bus decode
  wire wb_req = WB_CYC_I && WB_STB_I;
  wire hit_map = (WB_ADR_I == `MRW_OFS_MAP_CTL);
  wire hit_base = (WB_ADR_I == `MRW_OFS_WIN_BASE);
  wire hit_endian = (WB_ADR_I == `MRW_OFS_ENDIAN);
  wire hit_swap = (WB_ADR_I == `MRW_OFS_SWAP);
  wire hit_seq = (WB_ADR_I == `MRW_OFS_SEQ_OPT);
  wire hit_misc = (WB_ADR_I == `MRW_OFS_MISC);
  wire hit_adv = (WB_ADR_I == `MRW_OFS_ADV_FUNC);
  wire hit_stat = (WB_ADR_I == `MRW_OFS_STATUS);
  wire hit_any = hit_map || hit_base || hit_endian || hit_swap || hit_seq || hit_misc || hit_adv || hit_stat;
  // Write lands only at the edge the master sees the answer
  wire wb_commit = wb_req && WB_WE_I && (wb_state_reg == MRW_WB_ANSWER) && !miss_reg;
  wire wr_lane0 = wb_commit && WB_SEL_I[0];
  wire wr_lane1 = wb_commit && WB_SEL_I[1];

  // ****************************************
  // Mode decode
  // ****************************************
  // legacy select value
  wire sel_legacy = (map_sel_reg == `MRW_MAP_SEL_LEGACY);
  wire alt_legacy = !map_sel_reg[0] && adv_legacy_reg;
  wire legacy_on = sel_legacy || alt_legacy;
  wire new_on = (map_sel_reg == `MRW_MAP_SEL_NEW);
  // packed follows map bit 3
  // Bit 3 of the control word is the low select bit
  wire packed_en = map_sel_reg[0];

  // port I/O blocked when memory only
  assign IO_PORT_EN = !((legacy_on || new_on) && mmio_only_reg);

  // Status word shows live mode and last decode
  mrw_region_t last_region_reg;
  logic last_reject_reg;
  wire [31:0] status_word = {23'h000000, last_reject_reg, last_region_reg, packed_en, new_on,
                             legacy_on, IO_PORT_EN};

  // Read mux, reserved bits read as zero
  wire [31:0] rd_mux = hit_map ? {27'h0000000, map_sel_reg, lin_swap_reg, 1'b0} :
                       hit_base ? {24'h000000, win_base_reg, 2'h0} :
                       hit_endian ? {30'h00000000, endian_reg} :
                       hit_swap ? {25'h0000000, img_swap_reg, 5'h00} :
                       hit_seq ? {24'h000000, mmio_only_reg, 7'h00} :
                       hit_misc ? {22'h000000, wide_wr_reg, 9'h000} :
                       hit_adv ? {26'h0000000, adv_legacy_reg, 5'h00} :
                       hit_stat ? status_word : 32'h00000000;

  // ****************************************
  // Wishbone slave sequencing
  // ****************************************
  // One answer cycle, then idle so ack falls after one clock
  always_comb begin
    wb_state_next = wb_state_reg;
    unique case (wb_state_reg)
      MRW_WB_IDLE: begin
        if (wb_req) begin
          wb_state_next = MRW_WB_ANSWER;
        end
      end
      MRW_WB_ANSWER: begin
        wb_state_next = MRW_WB_IDLE;
      end
      default: begin
        wb_state_next = MRW_WB_IDLE;
      end
    endcase
  end

  assign WB_ACK_O = (wb_state_reg == MRW_WB_ANSWER) && !miss_reg;
  assign WB_ERR_O = (wb_state_reg == MRW_WB_ANSWER) && miss_reg;
  assign WB_DAT_O = rd_data_reg;

  // State and captured read data
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      wb_state_reg <= MRW_WB_IDLE;
      rd_data_reg <= 32'h00000000;
      miss_reg <= 1'b0;
    end else begin
      wb_state_reg <= wb_state_next;
      if ((wb_state_reg == MRW_WB_IDLE) && wb_req) begin
        rd_data_reg <= rd_mux;
        miss_reg <= !hit_any;
      end
    end
  end

  // ****************************************
  // Register writes
  // ****************************************
  // PCI strap resets to new scheme
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      map_sel_reg <= strap_sync_reg ? `MRW_MAP_SEL_NEW : `MRW_MAP_SEL_OFF;
      lin_swap_reg <= 2'h0;
      win_base_reg <= 6'h00;
      endian_reg <= 2'h0;
      img_swap_reg <= 2'h0;
      mmio_only_reg <= 1'b0;
      adv_legacy_reg <= 1'b0;
    end else begin
      if (wr_lane0 && hit_map) begin
        map_sel_reg <= WB_DAT_I[4:3];
        lin_swap_reg <= WB_DAT_I[2:1];
      end
      if (wr_lane0 && hit_base) begin
        win_base_reg <= WB_DAT_I[7:2];
      end
      if (wr_lane0 && hit_endian) begin
        endian_reg <= WB_DAT_I[1:0];
      end
      if (wr_lane0 && hit_swap) begin
        img_swap_reg <= WB_DAT_I[6:5];
      end
      if (wr_lane0 && hit_seq) begin
        mmio_only_reg <= WB_DAT_I[`MRW_SEQ_MMIO_ONLY_BIT];
      end
      if (wr_lane0 && hit_adv) begin
        adv_legacy_reg <= WB_DAT_I[`MRW_ADV_LEGACY_BIT];
      end
    end
  end

  // Wide write enable lives in the upper lane
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      wide_wr_reg <= 1'b0;
    end else if (wr_lane1 && hit_misc) begin
      wide_wr_reg <= WB_DAT_I[`MRW_MISC_WIDE_WR_BIT];
    end
  end


  // ****************************************
  // Legacy A segment decode
  // ****************************************
  wire in_a_seg = (HOST_ADDR[31:16] == `MRW_LEG_SEG);
  // image port in lower 32 KB
  wire leg_image = in_a_seg && (HOST_ADDR[15:0] < `MRW_LEG_REG_FLOOR);
  wire leg_reg = in_a_seg && (HOST_ADDR[15:0] >= `MRW_LEG_REG_FLOOR);
  wire leg_hit = legacy_on && in_a_seg;
  mrw_region_t leg_region;
  assign leg_region = leg_image ? MRW_RG_IMAGE : (leg_reg ? MRW_RG_ENH_REG : MRW_RG_NONE);

  // ****************************************
  // New window decode
  // ****************************************
  // base on address 31-26
  wire win_hit = new_on && (HOST_ADDR[31:26] == win_base_reg);
  // upper 32 MB is big endian
  wire big_half = HOST_ADDR[25];
  mrw_region_t new_region;

  mrw_region_decode u_region (
    .half_offset(HOST_ADDR[24:0]),
    .packed_en(packed_en),
    .region(new_region)
  );

  // ****************************************
  // Width checks
  // ****************************************
  wire acc_half = is_half(HOST_BE);
  wire acc_word = (HOST_BE == 4'hf);
  // wide writes gated by misc bit 9
  wire leg_width_ok = acc_half || (acc_word && HOST_WE && wide_wr_reg);
  wire new_width_ok = acc_half || (acc_word && HOST_WE);
  wire sel_new = win_hit;
  mrw_region_t pick_region;
  assign pick_region = sel_new ? new_region : (leg_hit ? leg_region : MRW_RG_NONE);
  wire width_ok = !is_reg_area(pick_region) || (sel_new ? new_width_ok : leg_width_ok);

  // ****************************************
  // Swap select
  // ****************************************
  // swap field per area, big half only
  wire [1:0] swap_pick = (pick_region == MRW_RG_LINEAR) ? lin_swap_reg :
                         ((pick_region == MRW_RG_IMAGE) && HOST_WE) ? img_swap_reg : endian_reg;
  wire [1:0] swap_out = (sel_new && big_half) ? swap_pick : 2'h0;

  // Offset inside the chosen area
  wire [21:0] off_out = (pick_region == MRW_RG_LINEAR) ? HOST_ADDR[21:0] :
                        (pick_region == MRW_RG_IMAGE) ? {7'h00, HOST_ADDR[14:0]} :
                        {6'h00, HOST_ADDR[15:0]};

  // claim only for an enabled scheme
  wire claim = sel_new || leg_hit;
  wire reject = claim && ((pick_region == MRW_RG_NONE) || !width_ok);
  // wide packed write covers a pair
  wire pair = (pick_region == MRW_RG_PACKED) && acc_word && HOST_WE && !reject;

  // ****************************************
  // Registered decode result
  // ****************************************
  // result one clock after request
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      DEC_VALID <= 1'b0;
      DEC_CLAIM <= 1'b0;
      DEC_REJECT <= 1'b0;
      DEC_REGION <= MRW_RG_NONE;
      DEC_OFFSET <= 22'h000000;
      DEC_BIG <= 1'b0;
      DEC_SWAP <= 2'h0;
      DEC_PAIR <= 1'b0;
    end else begin
      DEC_VALID <= HOST_REQ;
      DEC_CLAIM <= HOST_REQ && claim;
      DEC_REJECT <= HOST_REQ && reject;
      DEC_PAIR <= HOST_REQ && pair;
      if (HOST_REQ) begin
        DEC_REGION <= reject ? MRW_RG_NONE : pick_region;
        DEC_OFFSET <= off_out;
        DEC_BIG <= sel_new && big_half;
        DEC_SWAP <= swap_out;
      end
    end
  end

  // Last decode kept for the status word
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      last_region_reg <= MRW_RG_NONE;
      last_reject_reg <= 1'b0;
    end else if (HOST_REQ && claim) begin
      last_region_reg <= pick_region;
      last_reject_reg <= reject;
    end
  end
endmodule

// >>> mrw_window_decoder_assertions.sv
`timescale 1ns/1ps
// ****************************************
// Port-level checker for the window decoder
// ****************************************
module mrw_window_decoder_checker
  import mrw_pkg::*;
(
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // Control bus handshake
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_ACK_O,
  input wire logic WB_ERR_O,
  // Host request
  input wire logic HOST_REQ,
  input wire logic [31:0] HOST_ADDR,
  input wire logic HOST_WE,
  input wire logic [3:0] HOST_BE,
  // Decode result
  input wire logic DEC_VALID,
  input wire logic DEC_CLAIM,
  input wire logic DEC_REJECT,
  input wire mrw_pkg::mrw_region_t DEC_REGION,
  input wire logic DEC_BIG,
  input wire logic [1:0] DEC_SWAP,
  input wire logic DEC_PAIR
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  a_answer_next: assert property (HOST_REQ |=> DEC_VALID) else $error("decode missing after request");
  // valid quiet and region held between requests
  a_quiet_idle: assert property (!HOST_REQ |=> !DEC_VALID && $stable(DEC_REGION))
    else $error("decode moved without request");
  // claim and pair only with a result
  a_claim_valid: assert property (DEC_CLAIM || DEC_PAIR |-> DEC_VALID) else $error("claim without valid");
  a_reject_none: assert property (DEC_REJECT |-> DEC_CLAIM && DEC_REGION == MRW_RG_NONE)
    else $error("rejected cycle has a region");
  // half chosen by address bit 25
  a_half_select: assert property (HOST_REQ |=> DEC_CLAIM |-> DEC_BIG == $past(HOST_ADDR[25]))
    else $error("endian half mismatch");
  a_little_swap: assert property (DEC_VALID && !DEC_BIG |-> DEC_SWAP == 2'b00) else $error("swap in little half");
  a_wide_read: assert property (HOST_REQ && !HOST_WE && HOST_BE == 4'hf |=>
    !(DEC_REGION inside {MRW_RG_PACKED, MRW_RG_ENH_REG, MRW_RG_SYS_REG, MRW_RG_PF_REG}))
    else $error("wide read reached a register");
  // pair only from a 32-bit write
  a_pair_wide: assert property (HOST_REQ && !(HOST_WE && HOST_BE == 4'hf) |=> !DEC_PAIR)
    else $error("pair without wide write");
  // bus answered one clock after taken
  a_bus_answer: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_ERR_O |=> WB_ACK_O ^ WB_ERR_O)
    else $error("bus answer missing");
  a_answer_pulse: assert property (WB_ACK_O || WB_ERR_O |=> !WB_ACK_O && !WB_ERR_O)
    else $error("bus answer too long");
endmodule
bind mrw_window_decoder mrw_window_decoder_checker u_chk (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
  .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .WB_ERR_O(WB_ERR_O),
  .HOST_REQ(HOST_REQ), .HOST_ADDR(HOST_ADDR), .HOST_WE(HOST_WE), .HOST_BE(HOST_BE),
  .DEC_VALID(DEC_VALID), .DEC_CLAIM(DEC_CLAIM), .DEC_REJECT(DEC_REJECT), .DEC_REGION(DEC_REGION),
  .DEC_BIG(DEC_BIG), .DEC_SWAP(DEC_SWAP), .DEC_PAIR(DEC_PAIR));

// >>> mrw_host_model.sv
`timescale 1ns/1ps
module mrw_host_model (
  // Clock
  input wire logic clk,
  // Memory cycle toward the decoder
  output logic req,
  output logic [31:0] addr,
  output logic we,
  output logic [3:0] be
);
  // Idle at time zero
  initial begin
    req = 1'b0;
    addr = 32'h0;
    we = 1'b0;
    be = 4'h0;
  end
  // One cycle: request for one edge, then released lines show the inverse
  task automatic access(input logic [31:0] a, input logic w, input logic [3:0] b);
    @(posedge clk);
    req <= 1'b1;
    addr <= (a[31:16] == 16'h000a) ? {a[31:1], 1'b0} : a;
    we <= w;
    be <= b;
    @(posedge clk);
    req <= 1'b0;
    addr <= ~a;
    we <= ~w;
    be <= ~b;
  endtask
endmodule

// >>> mrw_window_decoder_bench.sv
`timescale 1ns/1ps
module mrw_window_decoder_bench;
  import mrw_pkg::*;
  // ****************************************
  // Signals and model state
  // ****************************************
  logic clk_sys, rst_n, pci_strap, wb_cyc, wb_stb, wb_we, wb_ack, wb_err;
  logic [4:0] wb_adr;
  logic [31:0] wb_dat, wb_q, haddr;
  logic hreq, hwe, dv, dc, dr, dbig, dpair, io_en, e_cl, e_rj, e_bg, e_pr, er;
  logic [3:0] hbe, wb_sel, sel_w;
  mrw_region_t dreg;
  logic [3:0] e_rg;
  logic [21:0] doff, e_of;
  logic [1:0] dswap, e_sw;
  logic [31:0] q, a;
  int error_cnt, checks, cycles, seed, h;
  int msel, lswap, base, endf, swapf, seq7, misc9, adv5;
  int offs[17] = '{'h0123456, 'h1000000, 'h1007ffe, 'h1008010, 'h1008100, 'h100816c, 'h10083c4,
    'h1008502, 'h1008504, 'h100850c, 'h10086e8, 'h100eeea, 'h1014000, 'h1008400, 'h10082e8,
    'h1010000, 'h1018080};
  mrw_window_decoder dut (.CLK_SYS(clk_sys), .RST_N(rst_n), .PCI_STRAP(pci_strap),
    .WB_CYC_I(wb_cyc), .WB_STB_I(wb_stb), .WB_WE_I(wb_we), .WB_ADR_I(wb_adr), .WB_SEL_I(wb_sel),
    .WB_DAT_I(wb_dat), .WB_DAT_O(wb_q), .WB_ACK_O(wb_ack), .WB_ERR_O(wb_err),
    .HOST_REQ(hreq), .HOST_ADDR(haddr), .HOST_WE(hwe), .HOST_BE(hbe),
    .DEC_VALID(dv), .DEC_CLAIM(dc), .DEC_REJECT(dr), .DEC_REGION(dreg), .DEC_OFFSET(doff),
    .DEC_BIG(dbig), .DEC_SWAP(dswap), .DEC_PAIR(dpair), .IO_PORT_EN(io_en));
  mrw_host_model host (.clk(clk_sys), .req(hreq), .addr(haddr), .we(hwe), .be(hbe));
  // Clock at 25 MHz
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // Watchdog against a hang
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles > 5000) begin
      error_cnt++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Classic single cycle; waits on the answer, the watchdog bounds it
  task automatic wb(input logic w, input logic [4:0] ad, input logic [31:0] d);
    @(posedge clk_sys);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= ad;
    wb_sel <= sel_w;
    wb_dat <= d;
    do @(posedge clk_sys); while (wb_ack !== 1'b1 && wb_err !== 1'b1);
    q = wb_q;
    er = wb_err;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_dat <= ~d;
  endtask
  // Write a control register and mirror it in the model
  task automatic wr(input logic [4:0] ad, input logic [31:0] d);
    wb(1'b1, ad, d);
    case (ad)
      5'h00: {msel, lswap} = {30'h0, d[4:3], 30'h0, d[2:1]};
      5'h04: base = d[7:2];
      5'h08: endf = d[1:0];
      5'h0c: swapf = d[6:5];
      5'h10: seq7 = d[7];
      5'h14: misc9 = d[9];
      5'h18: adv5 = d[5];
      default: ;
    endcase
  endtask
  // Expected decode of one host cycle
  task automatic predict(input logic [31:0] x, input logic w, input logic [3:0] b);
    logic [24:0] o;
    logic ok;
    o = x[24:0];
    ok = b != 4'hf || w;
    {e_cl, e_rj, e_bg, e_pr, e_sw, e_of, e_rg} = '0;
    if (msel == 3 && x[31:26] == base[5:0]) begin
      e_cl = 1;
      e_bg = x[25];
      e_of = {6'h0, o[15:0]};
      if (o < 25'h1000000) {e_rg, e_of, e_rj} = {MRW_RG_LINEAR, o[21:0], o >= 25'h0400000};
      else if (o <= 25'h1007fff) {e_rg, e_of} = {MRW_RG_IMAGE, 7'h0, o[14:0]};
      else if (o <= 25'h100803f) e_rg = MRW_RG_PCI_CFG;
      else if (o >= 25'h1008100 && o <= 25'h100816f) {e_rg, e_rj, e_pr} = {MRW_RG_PACKED, !ok, w && b == 4'hf};
      else if (o inside {25'h10082e8, 25'h10082ea}) {e_rg, e_rj} = {MRW_RG_ENH_REG, !ok};
      else if (o >= 25'h10083b0 && o <= 25'h10083df) e_rg = MRW_RG_VGA;
      else if (o inside {25'h1008502, 25'h1008504, 25'h1008508, 25'h100850c}) {e_rg, e_rj} = {MRW_RG_SYS_REG, !ok};
      else if (o >= 25'h10086e8 && o <= 25'h100eeea) {e_rg, e_rj} = {MRW_RG_ENH_REG, !ok};
      else if (o >= 25'h1010000 && o <= 25'h1013fff) e_rg = MRW_RG_PF_DATA;
      else if (o >= 25'h1014000 && o <= 25'h1017fff) e_rg = MRW_RG_PF_MASK;
      else if (o >= 25'h1018080 && o <= 25'h101809f) {e_rg, e_rj} = {MRW_RG_PF_REG, !ok};
      else e_rj = 1;
      if (e_bg) e_sw = 2'((e_rg == MRW_RG_LINEAR) ? lswap : (e_rg == MRW_RG_IMAGE && w) ? swapf : endf);
    end else if ((msel == 2 || (msel == 0 && adv5 == 1)) && x[31:16] == 16'h000a) begin
      e_cl = 1;
      if (!x[15]) {e_rg, e_of} = {MRW_RG_IMAGE, 7'h0, x[14:0]};
      else {e_rg, e_of, e_rj} = {MRW_RG_ENH_REG, 6'h0, x[15:0], b == 4'hf && !(w && misc9 == 1)};
    end
    if (e_rj) e_rg = MRW_RG_NONE;
  endtask
  // Drive one host cycle; compare valid and claim, the rest when claimed, offset and swap only when not rejected
  task automatic probe(input logic [31:0] x, input logic w, input logic [3:0] b);
    host.access(x, w, b);
    #1;
    predict(x, w, b);
    check("valid", 1, dv);
    check("claim", e_cl, dc);
    if (e_cl) begin
      check("reject", e_rj, dr);
      check("region", e_rg, dreg);
      check("pair", e_pr, dpair);
      check("big", e_bg, dbig);
    end
    if (e_cl && !e_rj) begin
      check("offset", e_of, doff);
      check("swap", e_sw, dswap);
    end
  endtask
  // Main sequence
  initial begin
    {error_cnt, checks, cycles, msel, lswap, base, endf, swapf, seq7, misc9, adv5} = '0;
    {rst_n, wb_cyc, wb_stb, wb_we, wb_adr, wb_dat, wb_sel} = '0;
    pci_strap = 1'b1;
    sel_w = 4'hf;
    seed = $urandom(32'hd80276b3);
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    msel = 3;
    wb(1'b0, 5'h00, 0);
    check("select", 2'h3, q[4:3]);
    wb(1'b0, 5'h1c, 0);
    check("status", 4'hd, q[3:0]);
    wb(1'b0, 5'h02, 0);
    check("unmapped", 1, er);
    wr(5'h04, (1 + $urandom % 63) << 2);
    wr(5'h08, $urandom & 3);
    wr(5'h0c, $urandom & 32'h60);
    wr(5'h00, 32'h18 | ($urandom & 6));
    wb(1'b0, 5'h04, 0);
    check("base", base, q[7:2]);
    foreach (offs[i]) begin
      for (h = 0; h < 2; h++) begin
        a = {base[5:0], h[0], offs[i][24:0]};
        probe(a, 1'b0, 4'h3);
        probe(a, 1'b1, 4'hf);
        probe(a, 1'b0, 4'hf);
      end
    end
    repeat (16) probe({base[5:0], 1'($urandom), 2'h0, 23'($urandom)}, 1'($urandom), 4'hc);
    probe({base[5:0] ^ 6'h01, 26'h1000000}, 1'b0, 4'h3);
    wr(5'h10, 32'h80);
    #1;
    check("io port", 0, io_en);
    wr(5'h10, 0);
    wr(5'h00, 32'h10);
    // legacy image writes, then register widths with and without misc bit 9
    probe(32'h000a0000, 1'b1, 4'hf);
    probe(32'h000a7ffe, 1'b1, 4'h3);
    probe(32'h000a82e8, 1'b0, 4'h3);
    probe(32'h000a82e8, 1'b1, 4'hf);
    wr(5'h14, 32'h200);
    probe(32'h000a82e8, 1'b1, 4'hf);
    probe(32'h000a86e8, 1'b0, 4'hf);
    // Low lane alone must leave the wide write bit set
    sel_w = 4'h1;
    wb(1'b1, 5'h14, 0);
    sel_w = 4'hf;
    probe(32'h000a82e8, 1'b1, 4'hf);
    probe({base[5:0], 26'h1000000}, 1'b0, 4'h3);
    wr(5'h18, 32'h20);
    wr(5'h00, 0);
    probe(32'h000a0100, 1'b0, 4'h3);
    wr(5'h00, 32'h08);
    probe(32'h000a0100, 1'b0, 4'h3);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    pci_strap <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    {msel, lswap, base, endf, swapf, seq7, misc9, adv5} = '0;
    wb(1'b0, 5'h00, 0);
    check("select", 0, q[4:3]);
    probe(32'h01000000, 1'b0, 4'h3);
    wrap_up();
  end
endmodule
